// File: src/adcseq_top.sv
// Purpose: scan sequencer of a multi-channel SAR converter with host handshake
// Assumes: all inputs synchronous to SYS_CLK; write strobes are one-cycle pulses
// Notes:   the analog converter follows ACQUIRE/CONVERT/CONV_CHANNEL and stores on RESULT_UPDATE
//          CONV_CHANNEL moves on with RESULT_UPDATE, so the converter latches the channel while CONVERT is high
module adcseq_top
  import adcseq_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESETN,
  input  wire logic                  SCAN_MODE_SELECT,
  input  wire logic [1:0]            CONVERSION_RATE_SELECT,
  input  wire logic [adcseq_pkg::SELW-1:0] CHANNEL_SELECT_0,
  input  wire logic [adcseq_pkg::SELW-1:0] CHANNEL_SELECT_1,
  input  wire logic                  CHANNEL_SELECT_WRITE,
  input  wire logic                  THRESHOLD_WRITE,
  input  wire logic                  INTERNAL_CONVERT_START,
  input  wire logic                  EXTERNAL_CONVERT_PIN,
  input  wire logic                  RESULT_READ,
  output logic [adcseq_pkg::CHW-1:0] CONV_CHANNEL,
  output logic                       ACQUIRE,
  output logic                       CONVERT,
  output logic                       NAP,
  output logic                       RESULT_UPDATE,
  output logic                       SCAN_BUSY,
  output logic                       DATA_READY_PIN_N,
  output logic                       DATA_READY_FLAG
);
  import adcseq_pkg::*;

  adcseq_state_t   st_r, st_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic [CHW-1:0]  ch_r, ch_nxt;
  logic            mode_r, ext_q_r;
  logic            acq_r, conv_r, nap_r, upd_r, busy_r;
  logic            acq_nxt, conv_nxt, nap_nxt, upd_nxt, busy_nxt;
  logic            flag_r, flag_nxt, pin_n_r, pin_n_nxt;
  logic [CW-1:0]   pcnt_r, pcnt_nxt;
  logic [NCH-1:0]  mask;
  logic [CHW:0]    first_ch, next_ch;
  logic [CW-1:0]   nap_len;
  logic            ext_rise, mode_chg, trig, start, abort, done;

  // lowest selected channel at or above 'from'; top bit set when none is left
  function automatic logic [CHW:0] find_ch(input logic [NCH-1:0] m, input logic [CHW:0] from);
    logic [CHW:0] r;
    r = {1'b1, {CHW{1'b0}}};
    for (int i = NCH - 1; i >= 0; i--) begin
      if ((i >= int'(from)) && m[i]) begin
        r = {1'b0, CHW'(i)};
      end
    end
    return r;
  endfunction : find_ch

  // event decode; the pin is taken as synchronous so only an edge detector is needed
  assign mask     = {CHANNEL_SELECT_1, CHANNEL_SELECT_0};
  assign ext_rise = EXTERNAL_CONVERT_PIN & ~ext_q_r;
  assign mode_chg = SCAN_MODE_SELECT != mode_r;
  assign trig     = INTERNAL_CONVERT_START | ext_rise;
  assign start    = trig & ~(INTERNAL_CONVERT_START & mode_chg);
  assign abort    = trig | mode_chg | CHANNEL_SELECT_WRITE | THRESHOLD_WRITE;
  assign first_ch = find_ch(mask, {(CHW + 1){1'b0}});
  assign next_ch  = find_ch(mask, {1'b0, ch_r} + {{CHW{1'b0}}, 1'b1});

  // nap share of a slow acquisition
  always_comb begin
    case (CONVERSION_RATE_SELECT)
      RATE_MAX: nap_len = CNT_ZERO;
      RATE_1:   nap_len = NAP1_CYC;
      RATE_2:   nap_len = NAP2_CYC;
      default:  nap_len = NAP3_CYC;
    endcase
  end

  // sequencer next state
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = (cnt_r != CNT_ZERO) ? cnt_r - CNT_ONE : CNT_ZERO;
    ch_nxt  = ch_r;
    upd_nxt = 1'b0;
    done    = 1'b0;
    case (st_r)
      ST_IDLE: begin
        cnt_nxt = CNT_ZERO;
      end
      ST_SYNC: begin
        if (cnt_r == CNT_ZERO) begin
          if (first_ch[CHW]) begin
            st_nxt = ST_IDLE;
          end else begin
            ch_nxt  = first_ch[CHW-1:0];
            st_nxt  = (nap_len == CNT_ZERO) ? ST_ACQ : ST_NAP;
            cnt_nxt = (nap_len == CNT_ZERO) ? ACQ0_CYC - CNT_ONE : nap_len - CNT_ONE;
          end
        end
      end
      ST_NAP: begin
        if (cnt_r == CNT_ZERO) begin
          st_nxt  = ST_ACQ;
          cnt_nxt = ACQ0_CYC - CNT_ONE;
        end
      end
      ST_ACQ: begin
        if (cnt_r == CNT_ZERO) begin
          st_nxt  = ST_CONV;
          cnt_nxt = CONV_CYC - CNT_ONE;
        end
      end
      // each channel gets a sample slot of its own, one after another
      ST_CONV: begin
        if (cnt_r == CNT_ZERO) begin
          upd_nxt = 1'b1;
          st_nxt  = (nap_len == CNT_ZERO) ? ST_ACQ : ST_NAP;
          cnt_nxt = (nap_len == CNT_ZERO) ? ACQ0_CYC - CNT_ONE : nap_len - CNT_ONE;
          if (!next_ch[CHW]) begin
            ch_nxt = next_ch[CHW-1:0];
          end else begin
            done = 1'b1;
            if (mode_r == MODE_CONT && !first_ch[CHW]) begin
              ch_nxt = first_ch[CHW-1:0];
            end else begin
              st_nxt  = ST_IDLE;
              cnt_nxt = CNT_ZERO;
            end
          end
        end
      end
      default: begin
        st_nxt  = ST_IDLE;
        cnt_nxt = CNT_ZERO;
      end
    endcase
    if (start) begin
      st_nxt  = ST_SYNC;
      cnt_nxt = SYNC_CYC - CNT_ONE;
      upd_nxt = 1'b0;
      done    = 1'b0;
    end else if (abort) begin
      st_nxt  = ST_IDLE;
      cnt_nxt = CNT_ZERO;
      upd_nxt = 1'b0;
      done    = 1'b0;
    end
    acq_nxt  = st_nxt == ST_ACQ;
    conv_nxt = st_nxt == ST_CONV;
    nap_nxt  = st_nxt == ST_NAP;
    busy_nxt = st_nxt != ST_IDLE;
  end

  // host handshake next state; a set in the same cycle as a clear wins
  always_comb begin
    flag_nxt = flag_r;
    pcnt_nxt = (pcnt_r != CNT_ZERO) ? pcnt_r - CNT_ONE : CNT_ZERO;
    if (RESULT_READ || ext_rise) begin
      flag_nxt = 1'b0;
    end
    if (done && mode_r == MODE_ONE) begin
      flag_nxt = 1'b1;
    end
    if (done && mode_r == MODE_CONT) begin
      pcnt_nxt = PULSE_CYC;
    end
    // flag held at zero in continuous mode
    if (mode_r == MODE_CONT) begin
      flag_nxt = 1'b0;
    end
    pin_n_nxt = ~(flag_nxt | (pcnt_nxt != CNT_ZERO));
  end

  // all sequencer state registered here; outputs come straight from these flops
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r    <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      ch_r    <= {CHW{1'b0}};
      mode_r  <= MODE_ONE;
      ext_q_r <= 1'b0;
      acq_r   <= 1'b0;
      conv_r  <= 1'b0;
      nap_r   <= 1'b0;
      upd_r   <= 1'b0;
      busy_r  <= 1'b0;
      flag_r  <= 1'b0;
      pcnt_r  <= CNT_ZERO;
      pin_n_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      ch_r    <= ch_nxt;
      mode_r  <= SCAN_MODE_SELECT;
      ext_q_r <= EXTERNAL_CONVERT_PIN;
      acq_r   <= acq_nxt;
      conv_r  <= conv_nxt;
      nap_r   <= nap_nxt;
      upd_r   <= upd_nxt;
      busy_r  <= busy_nxt;
      flag_r  <= flag_nxt;
      pcnt_r  <= pcnt_nxt;
      pin_n_r <= pin_n_nxt;
    end
  end

  assign CONV_CHANNEL     = ch_r;
  assign ACQUIRE          = acq_r;
  assign CONVERT          = conv_r;
  assign NAP              = nap_r;
  assign RESULT_UPDATE    = upd_r;
  assign SCAN_BUSY        = busy_r;
  assign DATA_READY_FLAG  = flag_r;
  assign DATA_READY_PIN_N = pin_n_r;

  // helpers for the checks below: length of the latest conversion and age of the sync wait
  logic [CW-1:0]   conv_run_r, conv_run_nxt, sync_age_r, sync_age_nxt;
  always_comb begin
    conv_run_nxt = conv_r ? conv_run_r + CNT_ONE : CNT_ZERO;
    // a retrigger restarts the age, so only one unbroken wait is measured
    if (start) begin
      sync_age_nxt = CNT_ONE;
    end else if (st_r == ST_SYNC) begin
      sync_age_nxt = sync_age_r + CNT_ONE;
    end else begin
      sync_age_nxt = CNT_ZERO;
    end
  end

  // helper registers, not seen at the ports
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_run_r <= CNT_ZERO;
      sync_age_r <= CNT_ZERO;
    end else begin
      conv_run_r <= conv_run_nxt;
      sync_age_r <= sync_age_nxt;
    end
  end

  AST_ONESHOT_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    done && mode_r == MODE_ONE |=> st_r == ST_IDLE && !SCAN_BUSY) else $error("one-shot did not stop");
  AST_CONT_WRAP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    done && mode_r == MODE_CONT |=> SCAN_BUSY && CONV_CHANNEL == first_ch[CHW-1:0]) else $error("no wrap");
  AST_ABORT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    abort && !start |=> st_r == ST_IDLE && !ACQUIRE && !CONVERT) else $error("abort ignored");
  AST_TRIG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    start |=> st_r == ST_SYNC) else $error("trigger ignored");
  AST_START_MODE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INTERNAL_CONVERT_START && mode_chg |=> !SCAN_BUSY) else $error("start with mode change ran");
  AST_CONV_LEN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESULT_UPDATE |-> conv_run_r == CONV_CYC && !CONVERT) else $error("conversion length wrong");
  AST_NAP_RATE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $rose(NAP) |-> $past(CONVERSION_RATE_SELECT) != RATE_MAX) else $error("nap at full rate");
  AST_SYNC_BOUND: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_r == ST_SYNC |-> sync_age_r <= SYNC_CYC) else $error("sync too long");
  AST_FLAG_SET: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    done && mode_r == MODE_ONE |=> DATA_READY_FLAG && !DATA_READY_PIN_N) else $error("ready not shown");
  AST_FLAG_CLR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (RESULT_READ || ext_rise) && !done && pcnt_r == CNT_ZERO |=> !DATA_READY_FLAG && DATA_READY_PIN_N)
    else $error("ready not cleared");
  AST_PULSE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    done && mode_r == MODE_CONT |=> !DATA_READY_PIN_N [*8]) else $error("pulse too short");
  AST_CONT_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    mode_r == MODE_CONT |=> !DATA_READY_FLAG) else $error("flag set in continuous mode");
endmodule : adcseq_top

// File: src/adcseq_pkg.sv
// Purpose: shared constants and types of the conversion sequencer
// Assumes: one clock at 100 MHz, all times counted in its cycles
// Notes:   cycle counts are derived from the printed times below
package adcseq_pkg;
  localparam int CLK_NS   = 10;
  localparam int ACQ0_NS  = 375;
  localparam int ACQ1_NS  = 2375;
  localparam int ACQ2_NS  = 6375;
  localparam int ACQ3_NS  = 14375;
  localparam int CONV_NS  = 1625;
  localparam int SYNC_NS  = 4000;
  localparam int PULSE_NS = 1000;
  localparam int CW       = 11;
  localparam int NCH      = 16;
  localparam int CHW      = 4;
  localparam int SELW     = 8;

  // acquisition is a least time (round up), conversion a fixed slot (round down); sum is the sample period
  localparam logic [CW-1:0] ACQ0_CYC  = CW'((ACQ0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] ACQ1_CYC  = CW'((ACQ1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] ACQ2_CYC  = CW'((ACQ2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] ACQ3_CYC  = CW'((ACQ3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] CONV_CYC  = CW'(CONV_NS / CLK_NS);
  localparam logic [CW-1:0] SYNC_CYC  = CW'(SYNC_NS / CLK_NS);
  localparam logic [CW-1:0] PULSE_CYC = CW'(PULSE_NS / CLK_NS);
  // the part of a slow acquisition spent napping
  localparam logic [CW-1:0] NAP1_CYC  = ACQ1_CYC - ACQ0_CYC;
  localparam logic [CW-1:0] NAP2_CYC  = ACQ2_CYC - ACQ0_CYC;
  localparam logic [CW-1:0] NAP3_CYC  = ACQ3_CYC - ACQ0_CYC;
  localparam logic [CW-1:0] CNT_ZERO  = 11'h000;
  localparam logic [CW-1:0] CNT_ONE   = 11'h001;

  localparam logic [1:0] RATE_MAX = 2'h0;
  localparam logic [1:0] RATE_1   = 2'h1;
  localparam logic [1:0] RATE_2   = 2'h2;
  localparam logic       MODE_ONE = 1'h0;
  localparam logic       MODE_CONT = 1'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_NAP  = 5'h04,
    ST_ACQ  = 5'h08,
    ST_CONV = 5'h10
  } adcseq_state_t;
endpackage : adcseq_pkg

// File: test/adcseq_host.sv
// Purpose: host model that issues conversion triggers and reads results
// Assumes: tasks are entered just after a falling sys_clk edge
// Notes:   each strobe is high for exactly one clock cycle
module adcseq_host (
  input  wire logic sys_clk,
  input  wire logic data_ready_pin_n,
  output logic      internal_convert_start,
  output logic      external_convert_pin,
  output logic      result_read
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle host: no trigger and no read pending
  initial begin
    internal_convert_start = 1'b0;
    external_convert_pin   = 1'b0;
    result_read            = 1'b0;
  end

  // one-cycle strobe: 0 start bit, 1 pin edge, 2 result read
  task automatic strobe(input int which);
    internal_convert_start = (which == 0);
    external_convert_pin   = (which == 1);
    result_read            = (which == 2);
    @(negedge sys_clk);
    internal_convert_start = 1'b0;
    external_convert_pin   = 1'b0;
    result_read            = 1'b0;
  endtask : strobe

  // read after done
  // waits a bounded time for data ready so the status is reset before the next start
  task automatic fetch(output bit ok);
    int n;
    n = 0;
    while (data_ready_pin_n !== 1'b0 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    ok = (n < 4000);
    strobe(2);
  endtask : fetch
endmodule : adcseq_host

// File: test/adcseq_top_test.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: inputs change at the falling SYS_CLK edge, outputs are sampled there too
// Notes:   cycle figures use 400 sync cycles and a 200-cycle slot at rate code 00
module adcseq_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adcseq_pkg::*;

  logic            sys_clk, resetn, mode, chw, thw, ics, ecp, rrd;
  logic [1:0]      rate;
  logic [SELW-1:0] sel0, sel1;
  logic [CHW-1:0]  chan;
  logic            acq, conv, nap, upd, busy, drdy_n, flag, saw_nap;
  int              fail_count, tests_run;

  adcseq_top uut (.SYS_CLK(sys_clk), .RESETN(resetn), .SCAN_MODE_SELECT(mode), .CONVERSION_RATE_SELECT(rate),
    .CHANNEL_SELECT_0(sel0), .CHANNEL_SELECT_1(sel1), .CHANNEL_SELECT_WRITE(chw), .THRESHOLD_WRITE(thw),
    .INTERNAL_CONVERT_START(ics), .EXTERNAL_CONVERT_PIN(ecp), .RESULT_READ(rrd), .CONV_CHANNEL(chan),
    .ACQUIRE(acq), .CONVERT(conv), .NAP(nap), .RESULT_UPDATE(upd), .SCAN_BUSY(busy),
    .DATA_READY_PIN_N(drdy_n), .DATA_READY_FLAG(flag));
  adcseq_host host (.sys_clk(sys_clk), .data_ready_pin_n(drdy_n), .internal_convert_start(ics),
    .external_convert_pin(ecp), .result_read(rrd));

  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic check_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %b seen %b", name, exp, got);
      fail_count++;
    end
  endtask : check_bit

  task automatic check_num(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %0d seen %0d", name, exp, got);
      fail_count++;
    end
  endtask : check_num

  // counts falling edges up to the k-th result update; a lost scan ends the run
  task automatic wait_upd(input int k, output int n);
    int u;
    n = 0;
    u = 0;
    saw_nap = 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
      if (nap === 1'b1) saw_nap = 1'b1;
      if (upd === 1'b1) u++;
      if (n > 6000) begin
        fail_count++;
        end_of_test();
      end
    end while (u < k);
  endtask : wait_upd

  task automatic t_oneshot();
    int n;
    bit ok;
    host.strobe(0);
    check_bit("busy after start", 1'b1, busy);
    wait_upd(1, n);
    check_num("single scan length", 600, n);
    check_bit("flag at end", 1'b1, flag);
    check_bit("pin at end", 1'b0, drdy_n);
    check_bit("busy at end", 1'b0, busy);
    check_bit("no nap at code 00", 1'b0, saw_nap);
    host.fetch(ok);
    check_bit("data ready seen", 1'b1, ok);
    check_bit("flag after read", 1'b0, flag);
    check_bit("pin after read", 1'b1, drdy_n);
  endtask : t_oneshot

  // two channels in the low mask, then an empty mask that only syncs
  task automatic t_channels();
    int n;
    sel0 = 8'h06;
    host.strobe(0);
    repeat (400) @(negedge sys_clk);
    check_bit("first channel acquiring", 1'b1, acq);
    check_num("first channel", 1, chan);
    wait_upd(1, n);
    check_num("first slot", 200, n);
    check_num("second channel", 2, chan);
    check_bit("second channel acquiring", 1'b1, acq);
    wait_upd(1, n);
    check_num("second slot", 200, n);
    check_bit("flag after both", 1'b1, flag);
    check_bit("idle after both", 1'b0, busy);
    host.strobe(2);
    sel0 = 8'h00;
    host.strobe(0);
    check_bit("empty mask busy", 1'b1, busy);
    repeat (399) @(negedge sys_clk);
    check_bit("empty mask syncing", 1'b1, busy);
    @(negedge sys_clk);
    check_bit("empty mask idle", 1'b0, busy);
    check_bit("empty mask no acquire", 1'b0, acq);
    check_bit("empty mask no data ready", 1'b0, flag);
    sel0 = 8'h01;
  endtask : t_channels

  // a second trigger mid-conversion restarts the whole sequence
  task automatic t_restart();
    int n;
    host.strobe(0);
    repeat (450) @(negedge sys_clk);
    check_bit("converting before retrigger", 1'b1, conv);
    host.strobe(0);
    check_bit("busy on retrigger", 1'b1, busy);
    check_bit("conversion cut by retrigger", 1'b0, conv);
    wait_upd(1, n);
    check_num("restarted scan length", 600, n);
    host.strobe(2);
  endtask : t_restart

  // two channels split over both masks at code 01, started by the pin
  task automatic t_nap();
    int n;
    sel1 = 8'h80;
    rate = 2'h1;
    host.strobe(1);
    wait_upd(2, n);
    check_num("two channel scan", 1200, n);
    check_num("last channel", 15, chan);
    check_bit("nap seen", 1'b1, saw_nap);
    check_bit("flag two channels", 1'b1, flag);
    host.strobe(1);
    check_bit("flag after pin", 1'b0, flag);
    check_bit("pin after pin", 1'b1, drdy_n);
    check_bit("busy after pin", 1'b1, busy);
    sel1 = 8'h00;
    thw = 1'b1;
    @(negedge sys_clk);
    thw = 1'b0;
  endtask : t_nap

  // continuous scans at every rate code: pulse width and period
  task automatic t_rates();
    int n, lo, per;
    mode = MODE_CONT;
    for (int c = 0; c < 4; c++) begin
      rate = c[1:0];
      repeat (2) @(negedge sys_clk);
      host.strobe(0);
      wait_upd(1, n);
      lo = 0;
      per = 0;
      do begin
        if (drdy_n === 1'b0) lo++;
        @(negedge sys_clk);
        per++;
      end while (upd !== 1'b1 && per < 2000);
      check_num("pulse width", 100, lo);
      check_num("sample period", 200 << c, per);
      check_bit("flag continuous", 1'b0, flag);
      check_bit("still running", 1'b1, busy);
      chw = 1'b1;
      @(negedge sys_clk);
      chw = 1'b0;
    end
    mode = MODE_ONE;
    rate = 2'h0;
  endtask : t_rates

  // abort events in mid-scan: threshold, channel select, mode, start with mode
  task automatic t_abort();
    for (int k = 0; k < 4; k++) begin
      // let a mode change of the previous step settle so the start bit is taken
      repeat (2) @(negedge sys_clk);
      host.strobe(0);
      repeat (450) @(negedge sys_clk);
      check_bit("converting before abort", 1'b1, conv);
      thw = (k == 0);
      chw = (k == 1);
      if (k > 1) mode = ~mode;
      if (k == 3) host.strobe(0);
      else @(negedge sys_clk);
      thw = 1'b0;
      chw = 1'b0;
      check_bit("busy after abort", 1'b0, busy);
      check_bit("acquire after abort", 1'b0, acq | conv);
      mode = MODE_ONE;
      repeat (3) @(negedge sys_clk);
      check_bit("idle after abort", 1'b0, busy);
    end
  endtask : t_abort

  // main sequence: reset, then the scenarios in turn
  initial begin
    fail_count = 0;
    tests_run = 0;
    resetn = 1'b0;
    mode = MODE_ONE;
    rate = 2'h0;
    sel0 = 8'h01;
    sel1 = 8'h00;
    chw = 1'b0;
    thw = 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit("pin in reset", 1'b1, drdy_n);
    check_bit("flag in reset", 1'b0, flag);
    resetn = 1'b1;
    @(negedge sys_clk);
    t_oneshot();
    t_channels();
    t_restart();
    t_nap();
    t_rates();
    t_abort();
    end_of_test();
  end
endmodule : adcseq_top_test
